// ### logic/csp_regs.svh
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// ==========================================================
// Register offsets
`define CSP_ADDR_W 8
`define CSP_OFF_STATUS 8'h01
`define CSP_OFF_PWR_CTL 8'h02
`define CSP_OFF_MISC 8'h16

// ==========================================================
// Power control fields
`define CSP_PWR_VPP_LSB 0
`define CSP_PWR_VPP_MSB 1
`define CSP_PWR_VCC_ON 4
`define CSP_PWR_AUTO 5
`define CSP_PWR_CARD_EN 7
`define CSP_PWR_RESET 8'h00
`define CSP_PWR_WMASK 8'hFF

// ==========================================================
// Misc control fields
`define CSP_MISC_LOWV 1
`define CSP_MISC_RESET 8'h00
`define CSP_MISC_WMASK 8'h02

// ==========================================================
// Status fields
`define CSP_ST_CD1 2
`define CSP_ST_CD2 3
`define CSP_ST_WP 4
`define CSP_ST_RDY 5
`define CSP_ST_PWR_ON 6
`define CSP_ST_VPP_OK 7

// ==========================================================
// Synchronised pin slots
`define CSP_PIN_N 6
`define CSP_PIN_GOOD 0
`define CSP_PIN_CD_A 1
`define CSP_PIN_CD_B 2
`define CSP_PIN_WP 3
`define CSP_PIN_RDY 4
`define CSP_PIN_VPP_N 5
`define CSP_PIN_RESET 6'h26

`endif

// ### logic/csp_pkg.sv
package csp_pkg;

// ==========================================================
// Programming-voltage field codes
typedef enum logic [1:0] {
    CSP_VPP_OFF = 2'b00,
    CSP_VPP_PASS = 2'b01,
    CSP_VPP_PROG = 2'b10,
    CSP_VPP_OFF2 = 2'b11
} csp_vpp_t;

typedef logic [7:0] csp_reg_t;

endpackage : csp_pkg

// ### logic/csp_sync_if.sv
`timescale 1ns/10ps
`include "csp_regs.svh"

interface csp_sync_if;
    logic [`CSP_PIN_N-1:0] raw;
    logic [`CSP_PIN_N-1:0] filt;

    modport filter (input raw, output filt);
    modport user (output raw, input filt);
endinterface : csp_sync_if

// ### logic/csp_pin_sync.sv
`timescale 1ns/10ps
`include "csp_regs.svh"

module csp_pin_sync import csp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pins in, filtered levels out
    csp_sync_if.filter pins
);

    logic [`CSP_PIN_N-1:0] s1_q;
    logic [`CSP_PIN_N-1:0] s2_q;
    logic [`CSP_PIN_N-1:0] s3_q;
    logic [`CSP_PIN_N-1:0] filt_q;
    // Idle levels per pin, one bit picked per slot
    localparam logic [`CSP_PIN_N-1:0] PIN_IDLE = `CSP_PIN_RESET;

    genvar i;
    generate
        for (i = 0; i < `CSP_PIN_N; i++) begin : g_pin
            // ======================================================
            // Three stages; first stage feeds only the second
            always_ff @(posedge clk) begin
                s1_q[i] <= pins.raw[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
            end

            // Change accepted once stages two and three agree
            always_ff @(posedge clk) begin
                if (srst) begin
                    filt_q[i] <= PIN_IDLE[i];
                end else if (s2_q[i] == s3_q[i]) begin
                    filt_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

    assign pins.filt = filt_q;

endmodule : csp_pin_sync

// ### logic/csp_socket_power.sv
// How it works
// - Status bit 4 shows write-protect pin
// - Status bit 5 shows card ready pin
// - Status bit 6 set only when supply applied
// - Status bit 7 is inverted programming-voltage-valid pin
// - Supply bad forces all power selects inactive
// - Supply bad or no card floats outputs
// - Supply bit clear keeps both selects high
// - Supply on drives one select, voltage chosen
// - Auto-power clear ignores card detect pins
// - Auto-power set needs both detects low
// - Field bits 1:0 pick programming voltage
// - Enable bit clear floats socket outputs
// - Enable, supply good, card present drive
// - All card strobes, address, data gated
// - Card present only when both detects low
`timescale 1ns/10ps
`include "csp_regs.svh"

module csp_socket_power import csp_pkg::*; #(
    parameter int ADDR_BITS = 26,
    parameter int DATA_BITS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [`CSP_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Power and card status pins
    input wire logic supply_good_in,
    input wire logic card_present_a_n,
    input wire logic card_present_b_n,
    input wire logic protect_or_width_in,
    input wire logic ready_or_card_irq_in,
    input wire logic prog_volt_valid_n,
    // Supply switch controls
    output logic supply_3v3_sel_n,
    output logic supply_5v_sel_n,
    output logic prog_volt_sel,
    output logic prog_pass_supply_sel,
    // Socket signals from the access engine
    input wire logic core_card_sel_high_n,
    input wire logic core_card_sel_low_n,
    input wire logic core_io_rd_n,
    input wire logic core_io_wr_n,
    input wire logic core_rd_en_n,
    input wire logic core_reg_sel_n,
    input wire logic core_card_reset,
    input wire logic core_wr_en_n,
    input wire logic [ADDR_BITS-1:0] core_addr,
    input wire logic [DATA_BITS-1:0] core_wdata,
    input wire logic core_data_drive,
    output logic [DATA_BITS-1:0] core_rdata,
    // Socket pins
    output logic card_sel_high_n,
    output logic card_sel_low_n,
    output logic io_rd_n,
    output logic io_wr_n,
    output logic card_rd_en_n,
    output logic card_reg_sel_n,
    output logic card_reset,
    output logic card_wr_en_n,
    output logic [ADDR_BITS-1:0] card_addr,
    output logic sock_ctl_oe_n,
    input wire logic [DATA_BITS-1:0] card_data_i,
    output logic [DATA_BITS-1:0] card_data_o,
    output logic card_data_oe_n
);

    // ==========================================================
    // Pin synchronisers
    csp_sync_if pin_bus ();

    assign pin_bus.raw[`CSP_PIN_GOOD] = supply_good_in;
    assign pin_bus.raw[`CSP_PIN_CD_A] = card_present_a_n;
    assign pin_bus.raw[`CSP_PIN_CD_B] = card_present_b_n;
    assign pin_bus.raw[`CSP_PIN_WP] = protect_or_width_in;
    assign pin_bus.raw[`CSP_PIN_RDY] = ready_or_card_irq_in;
    assign pin_bus.raw[`CSP_PIN_VPP_N] = prog_volt_valid_n;

    csp_pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pins(pin_bus.filter)
    );

    wire logic good_s = pin_bus.filt[`CSP_PIN_GOOD];
    wire logic cd_a_n_s = pin_bus.filt[`CSP_PIN_CD_A];
    wire logic cd_b_n_s = pin_bus.filt[`CSP_PIN_CD_B];
    wire logic wp_s = pin_bus.filt[`CSP_PIN_WP];
    wire logic rdy_s = pin_bus.filt[`CSP_PIN_RDY];
    wire logic vpp_ok_n_s = pin_bus.filt[`CSP_PIN_VPP_N];

    // ==========================================================
    // Register file
    csp_reg_t pwr_ctl_q;
    csp_reg_t pwr_ctl_d;
    csp_reg_t misc_q;
    csp_reg_t misc_d;
    csp_reg_t rdata_q;
    csp_reg_t rdata_d;
    csp_reg_t status_w;

    function automatic logic hit(input logic [`CSP_ADDR_W-1:0] a,
                                 input logic [`CSP_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    wire logic wr_pwr = reg_wr && hit(reg_addr, `CSP_OFF_PWR_CTL);
    wire logic wr_misc = reg_wr && hit(reg_addr, `CSP_OFF_MISC);

    // All power control bits writable, unused ones just store; misc keeps bit 1 only
    assign pwr_ctl_d = wr_pwr ? (reg_wdata & `CSP_PWR_WMASK) : pwr_ctl_q;
    assign misc_d = wr_misc ? (reg_wdata & `CSP_MISC_WMASK) : misc_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_ctl_q <= `CSP_PWR_RESET;
            misc_q <= `CSP_MISC_RESET;
        end else begin
            pwr_ctl_q <= pwr_ctl_d;
            misc_q <= misc_d;
        end
    end

    // ==========================================================
    // Power decisions
    wire logic vcc_on = pwr_ctl_q[`CSP_PWR_VCC_ON];
    wire logic auto_pwr = pwr_ctl_q[`CSP_PWR_AUTO];
    wire logic card_en = pwr_ctl_q[`CSP_PWR_CARD_EN];
    wire logic low_voltage_select = misc_q[`CSP_MISC_LOWV];
    wire csp_vpp_t prog_volt_field =
        csp_vpp_t'(pwr_ctl_q[`CSP_PWR_VPP_MSB:`CSP_PWR_VPP_LSB]);

    wire logic card_in = !cd_a_n_s && !cd_b_n_s;

    wire logic detect_ok = !auto_pwr || card_in;

    // Supply good and supply bit both needed
    wire logic power_act = good_s && vcc_on && detect_ok;

    wire logic sel_3v3_n_d = !(power_act && low_voltage_select);
    wire logic sel_5v_n_d = !(power_act && !low_voltage_select);

    wire logic vpp_prog_d = power_act && (prog_volt_field == CSP_VPP_PROG);
    wire logic vpp_pass_d = power_act && (prog_volt_field == CSP_VPP_PASS);

    // Drive only when enabled with card
    // Supply bit not required; card may run from outside power
    wire logic drive_en = good_s && card_in && card_en;

    // ==========================================================
    // Status assembly
    always_comb begin
        status_w = '0;
        status_w[`CSP_ST_CD1] = !cd_a_n_s;
        status_w[`CSP_ST_CD2] = !cd_b_n_s;
        status_w[`CSP_ST_WP] = wp_s;
        status_w[`CSP_ST_RDY] = rdy_s;
        status_w[`CSP_ST_PWR_ON] = power_act;
        status_w[`CSP_ST_VPP_OK] = !vpp_ok_n_s;
    end

    // Unmapped reads answer zero
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `CSP_OFF_STATUS: rdata_d = status_w;
                `CSP_OFF_PWR_CTL: rdata_d = pwr_ctl_q;
                `CSP_OFF_MISC: rdata_d = misc_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================================
    // Supply switch outputs
    logic sel_3v3_n_q;
    logic sel_5v_n_q;
    logic vpp_prog_q;
    logic vpp_pass_q;

    // Inactive at reset and whenever not permitted
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_3v3_n_q <= 1'b1;
            sel_5v_n_q <= 1'b1;
            vpp_prog_q <= 1'b0;
            vpp_pass_q <= 1'b0;
        end else begin
            sel_3v3_n_q <= sel_3v3_n_d;
            sel_5v_n_q <= sel_5v_n_d;
            vpp_prog_q <= vpp_prog_d;
            vpp_pass_q <= vpp_pass_d;
        end
    end

    assign supply_3v3_sel_n = sel_3v3_n_q;
    assign supply_5v_sel_n = sel_5v_n_q;
    assign prog_volt_sel = vpp_prog_q;
    assign prog_pass_supply_sel = vpp_pass_q;

    // ==========================================================
    // Socket signal gating
    logic ctl_oe_n_q;
    logic data_oe_n_q;
    logic [7:0] strobes_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic [DATA_BITS-1:0] wdata_q;
    logic [DATA_BITS-1:0] rdata_sock_q;

    // Strobes gathered so one register set follows
    wire logic [7:0] strobes_d = {core_card_sel_high_n, core_card_sel_low_n,
                                  core_io_rd_n, core_io_wr_n,
                                  core_rd_en_n, core_reg_sel_n,
                                  core_card_reset, core_wr_en_n};

    // Enables follow the gate; values pass unchanged
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_oe_n_q <= 1'b1;
            data_oe_n_q <= 1'b1;
        end else begin
            ctl_oe_n_q <= !drive_en;
            data_oe_n_q <= !(drive_en && core_data_drive);
        end
    end

    // Values are harmless while floated; idle strobes high, card_reset low
    always_ff @(posedge clk) begin
        if (srst) begin
            strobes_q <= 8'hFD;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_sock_q <= '0;
        end else begin
            strobes_q <= strobes_d;
            addr_q <= core_addr;
            wdata_q <= core_wdata;
            rdata_sock_q <= card_data_i;
        end
    end

    assign card_sel_high_n = strobes_q[7];
    assign card_sel_low_n = strobes_q[6];
    assign io_rd_n = strobes_q[5];
    assign io_wr_n = strobes_q[4];
    assign card_rd_en_n = strobes_q[3];
    assign card_reg_sel_n = strobes_q[2];
    assign card_reset = strobes_q[1];
    assign card_wr_en_n = strobes_q[0];
    assign card_addr = addr_q;
    assign sock_ctl_oe_n = ctl_oe_n_q;
    assign card_data_o = wdata_q;
    assign card_data_oe_n = data_oe_n_q;
    assign core_rdata = rdata_sock_q;

endmodule : csp_socket_power

// ### verification/csp_socket_power_monitor.sv
`timescale 1ns/10ps
`include "csp_regs.svh"

module csp_socket_power_monitor #(
    parameter int ADDR_BITS = 26
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and selects
    input wire logic supply_good_in,
    input wire logic card_present_a_n,
    input wire logic card_present_b_n,
    input wire logic supply_3v3_sel_n,
    input wire logic supply_5v_sel_n,
    input wire logic prog_volt_sel,
    input wire logic prog_pass_supply_sel,
    // Socket side
    input wire logic core_io_rd_n,
    input wire logic io_rd_n,
    input wire logic [ADDR_BITS-1:0] core_addr,
    input wire logic [ADDR_BITS-1:0] card_addr,
    input wire logic sock_ctl_oe_n,
    input wire logic card_data_oe_n,
    // Data path
    input wire logic core_data_drive,
    input wire logic [15:0] core_wdata,
    input wire logic [15:0] card_data_o,
    input wire logic [15:0] card_data_i,
    input wire logic [15:0] core_rdata
);
    // ========
    // Helpers
    logic [2:0] bad_q;
    logic [2:0] nc_q;
    logic [7:0] pwr_q;
    // Saturate at 7, safely past the pin filter latency
    always_ff @(posedge clk) begin
        bad_q <= (srst || supply_good_in) ? 3'h0 : bad_q + {2'h0, bad_q != 3'h7};
        nc_q <= (srst || !(card_present_a_n || card_present_b_n)) ? 3'h0 :
            nc_q + {2'h0, nc_q != 3'h7};
        pwr_q <= srst ? 8'h00 :
            (reg_wr && reg_addr == `CSP_OFF_PWR_CTL) ? reg_wdata : pwr_q;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // ========
    // Properties
    a_supply_bad_off: assert property (bad_q == 3'h7 |->
        supply_3v3_sel_n && supply_5v_sel_n && !prog_volt_sel &&
        !prog_pass_supply_sel && sock_ctl_oe_n) else $error("supply bad");
    a_no_card_float: assert property (nc_q == 3'h7 |->
        sock_ctl_oe_n && card_data_oe_n) else $error("no card drives");
    a_vcc_off_high: assert property (!pwr_q[4] && !$past(pwr_q[4]) |->
        supply_3v3_sel_n && supply_5v_sel_n) else $error("vcc off");
    a_one_supply_sel: assert property (
        supply_3v3_sel_n || supply_5v_sel_n) else $error("two selects");
    a_vpp_exclusive: assert property (
        !(prog_volt_sel && prog_pass_supply_sel)) else $error("two vpp");
    a_vpp_needs_vcc: assert property (prog_volt_sel ||
        prog_pass_supply_sel |-> !(supply_3v3_sel_n && supply_5v_sel_n))
        else $error("vpp alone");
    a_enable_off_float: assert property (!pwr_q[7] &&
        !$past(pwr_q[7]) |-> sock_ctl_oe_n && card_data_oe_n)
        else $error("enable off");
    a_data_oe_follow: assert property (1'b1 |=>
        card_data_oe_n == (sock_ctl_oe_n || !$past(core_data_drive)))
        else $error("data oe wrong");
    a_wdata_follow: assert property (1'b1 |=>
        card_data_o == $past(core_wdata)) else $error("card_data_o lag");
    a_rdata_back: assert property (1'b1 |=>
        core_rdata == $past(card_data_i)) else $error("core_rdata lag");
    a_data_oe_gated: assert property (!card_data_oe_n |->
        !sock_ctl_oe_n) else $error("data oe alone");
    a_strobe_follow: assert property (1'b1 |=>
        io_rd_n == $past(core_io_rd_n)) else $error("io_rd_n lag");
    a_addr_follow: assert property (1'b1 |=>
        card_addr == $past(core_addr)) else $error("card_addr lag");
    a_rdata_idle_zero: assert property (!reg_rd |=>
        reg_rdata == 8'h00) else $error("rdata not idle");
    a_status_low_zero: assert property (reg_rd && reg_addr ==
        `CSP_OFF_STATUS |=> reg_rdata[1:0] == 2'b00) else $error("bits 1:0");
endmodule : csp_socket_power_monitor

// ### verification/csp_card_model.sv
`timescale 1ns/10ps

module csp_card_model (
    // Clock
    input wire logic clk,
    // Socket pins from host
    input wire logic sock_ctl_oe_n,
    input wire logic card_sel_low_n,
    input wire logic card_rd_en_n,
    input wire logic card_data_oe_n,
    input wire logic [15:0] card_data_o,
    // Data back to host
    output logic [15:0] card_data_i
);
    logic [15:0] mem_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    always @(posedge clk) begin
        if (!card_data_oe_n) begin
            mem_q <= card_data_o;
        end
        last_q <= card_data_i;
    end
    // Undriven bus toggles so a stale value never looks valid
    assign card_data_i = (!sock_ctl_oe_n && !card_sel_low_n && !card_rd_en_n)
        ? mem_q : (!card_data_oe_n ? card_data_o : ~last_q);
endmodule : csp_card_model

// ### verification/card_socket_power_gating_tb_top.sv
`timescale 1ns/10ps
`include "csp_regs.svh"

module card_socket_power_gating_tb_top import csp_pkg::*;;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic supply_good_in = 1'b0, card_present_a_n = 1'b1;
    logic card_present_b_n = 1'b1, protect_or_width_in = 1'b0;
    logic ready_or_card_irq_in = 1'b0, prog_volt_valid_n = 1'b1;
    logic supply_3v3_sel_n, supply_5v_sel_n;
    logic prog_volt_sel, prog_pass_supply_sel;
    logic core_card_sel_high_n = 1'b1, core_card_sel_low_n = 1'b1;
    logic core_io_rd_n = 1'b1, core_io_wr_n = 1'b1, core_rd_en_n = 1'b1;
    logic core_reg_sel_n = 1'b1, core_card_reset = 1'b0;
    logic core_wr_en_n = 1'b1, core_data_drive = 1'b0;
    logic [25:0] core_addr = 26'h0000000, card_addr;
    logic [15:0] core_wdata = 16'h0000, core_rdata;
    logic [15:0] card_data_i, card_data_o;
    logic card_sel_high_n, card_sel_low_n, io_rd_n, io_wr_n, card_rd_en_n;
    logic card_reg_sel_n, card_reset, card_wr_en_n;
    logic sock_ctl_oe_n, card_data_oe_n;
    int n_errors = 0, checked = 0;
    integer seed = 32'hC791A26A;
    logic [7:0] exq[$];
    logic rd_seen = 1'b0, pin_seen = 1'b0, pin_req = 1'b0;
    wire [7:0] pin_word = {3'h0, sock_ctl_oe_n, supply_3v3_sel_n,
        supply_5v_sel_n, prog_volt_sel, prog_pass_supply_sel};

    always #4 clk = ~clk;

    csp_socket_power DUT (.*);
    csp_card_model u_card (.*);

    // ========
    // Result watcher
    always @(posedge clk) begin
        rd_seen <= reg_rd;
        pin_seen <= pin_req;
    end
    always @(negedge clk) begin
        if (rd_seen || pin_seen) begin
            logic [7:0] e, s;
            e = exq.pop_front();
            s = rd_seen ? reg_rdata : pin_word;
            checked++;
            if (s !== e) begin
                n_errors++;
                $display("BAD %s exp %h got %h",
                    rd_seen ? "reg_rdata" : "pin_word", e, s);
            end
        end
    end

    // ========
    // Engine traffic, random every cycle
    always @(posedge clk) begin
        logic [31:0] t;
        t = $random(seed);
        {core_card_sel_high_n, core_card_sel_low_n, core_io_rd_n, core_io_wr_n,
            core_rd_en_n, core_reg_sel_n, core_card_reset, core_wr_en_n}
            <= t[7:0];
        core_data_drive <= t[8];
        core_addr <= t[31:6];
        core_wdata <= t[23:8];
    end

    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        exq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd
    task pins(input logic [7:0] e);
        exq.push_back(e);
        pin_req <= 1'b1;
        @(posedge clk);
        pin_req <= 1'b0;
        @(posedge clk);
    endtask : pins
    task test_done;
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // ========
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [1:0] cd;
        logic [7:0] ctl;
        logic act, gate, good;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        pins(8'h1C);
        rd(`CSP_OFF_PWR_CTL, 8'h00);
        wr(`CSP_OFF_STATUS, 8'hFF);
        rd(8'h05, 8'h00);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            cd = r[2] ? 2'b00 : r[4:3];
            ctl = r[31:24];
            good = r[0] | r[1];
            supply_good_in <= good;
            card_present_a_n <= cd[0];
            card_present_b_n <= cd[1];
            protect_or_width_in <= r[11];
            ready_or_card_irq_in <= r[12];
            prog_volt_valid_n <= r[13];
            wr(`CSP_OFF_PWR_CTL, ctl);
            wr(`CSP_OFF_MISC, {r[21:16], r[10], r[15]});
            repeat (8) @(posedge clk);
            act = good & ctl[4] & (!ctl[5] | cd == 2'b00);
            gate = good & (cd == 2'b00) & ctl[7];
            pins({3'h0, !gate, !(act & r[10]), !(act & !r[10]),
                act & ctl[1:0] == 2'b10, act & ctl[1:0] == 2'b01});
            rd(`CSP_OFF_STATUS, {!r[13], act, r[12], r[11],
                !cd[1], !cd[0], 2'b00});
            rd(`CSP_OFF_PWR_CTL, ctl);
            rd(`CSP_OFF_MISC, {6'h00, r[10], 1'b0});
        end
        test_done;
    end

    initial begin
        #200000;
        n_errors++;
        test_done;
    end
endmodule : card_socket_power_gating_tb_top

bind csp_socket_power csp_socket_power_monitor #(.ADDR_BITS(ADDR_BITS))
    u_mon (.*);
